/* File: dv/uart_interrupt_timing_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_interrupt_timing_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rxd;
    logic txd;
    logic irq;
    logic [31:0] rd;
    logic errSeen;
    logic [7:0] b0;
    logic [7:0] b1;
    int fails = 0;
    int checks = 0;
    int n0;

    always #5 clk = ~clk;

    // baud divider 0 gives one tick per clock, sixteen clocks per bit
    uart_irq_core #(.BAUD_DIV_RESET(16'h0000)) u_dut (
        .clk(clk),
        .srst(srst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .rxd(rxd),
        .txd(txd),
        .irq(irq)
    );

    uart_remote_node #(.BIT_CLKS(16)) u_node (.clk(clk), .txd(txd), .rxd(rxd));

    function automatic logic [31:0] errBits(input int k);
        return (k == 0) ? 32'h00000010 : (k == 1) ? 32'h00000008 : 32'h00000028;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, s, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // the slave sets the wait; only the watchdog ends a hung transfer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
        apb(1'b0, a, 32'h00000000);
        chk(rd & m, e, s);
    endtask

    task automatic waitRx(input int n);
        for (int k = 0; k < 4000 && u_node.gotCount < n; k++) @(posedge clk);
        if (u_node.gotCount < n) begin
            fails++;
            $display("CHECK FAILED at %0t: serial frames missing", $time);
        end
    endtask

    task automatic results();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        results();
    end

    initial begin
        void'($urandom(56526));
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rdChk(uart_irq_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h00000006, "ctrl");
        rdChk(uart_irq_pkg::ADDR_LEVEL, 32'hFFFFFFFF, 32'h00000012, "level");
        rdChk(uart_irq_pkg::ADDR_BAUD, 32'hFFFFFFFF, 32'h00000000, "baud");
        rdChk(uart_irq_pkg::ADDR_RAW, 32'hFFFFFFFF, 32'h00000000, "raw");
        rdChk(8'h40, 32'hFFFFFFFF, 32'h00000000, "unmapped data");
        chk({31'h00000000, errSeen}, 32'h00000001, "unmapped error");
        apb(1'b1, uart_irq_pkg::ADDR_MASK, 32'h0000007F);
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        u_node.sendChar(b0, 1'b0, 1'b0, 1'b1);
        rdChk(uart_irq_pkg::ADDR_RAW, 32'h0000007F, 32'h00000001, "rx event");
        u_node.sendChar(b1, 1'b0, 1'b0, 1'b1);
        rdChk(uart_irq_pkg::ADDR_RAW, 32'h00000041, 32'h00000041, "overrun");
        rdChk(uart_irq_pkg::ADDR_DATA, 32'hFFFFFFFF, {24'h000000, b0}, "kept char");
        apb(1'b1, uart_irq_pkg::ADDR_MASK, 32'h00000000);
        chk({31'h00000000, irq}, 32'h00000000, "irq masked");
        rdChk(uart_irq_pkg::ADDR_MASKED, 32'hFFFFFFFF, 32'h00000000, "masked view");
        apb(1'b1, uart_irq_pkg::ADDR_MASK, 32'h0000007F);
        chk({31'h00000000, irq}, 32'h00000001, "irq unmasked");
        apb(1'b1, uart_irq_pkg::ADDR_CLEAR, 32'h0000007F);
        rdChk(uart_irq_pkg::ADDR_RAW, 32'hFFFFFFFF, 32'h00000000, "cleared");
        chk({31'h00000000, irq}, 32'h00000000, "irq cleared");
        // bad parity, bad stop, all-zero char with bad stop; ctrl write flushes each time
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, uart_irq_pkg::ADDR_CTRL, 32'h0000000E);
            b0 = (k == 2) ? 8'h00 : (8'($urandom) | 8'h01);
            // between the parity sample and the stop sample only parity may show
            fork
                u_node.sendChar(b0, 1'b1, (^b0) ^ (k == 0), k == 0);
                begin
                    repeat (156) @(posedge clk);
                    rdChk(uart_irq_pkg::ADDR_RAW, 32'h00000038, errBits(k) & 32'h00000010, "mid frame");
                end
            join
            rdChk(uart_irq_pkg::ADDR_RAW, 32'h00000038, errBits(k), "rx error");
            apb(1'b1, uart_irq_pkg::ADDR_CLEAR, 32'h0000007F);
        end
        apb(1'b1, uart_irq_pkg::ADDR_CTRL, 32'h00000007);
        apb(1'b1, uart_irq_pkg::ADDR_LEVEL, 32'h00000000);
        apb(1'b1, uart_irq_pkg::ADDR_CLEAR, 32'h0000007F);
        for (int i = 0; i < 4; i++) begin
            u_node.sendChar(8'($urandom), 1'b0, 1'b0, 1'b1);
            rdChk(uart_irq_pkg::ADDR_RAW, 32'h00000001, {31'h00000000, i == 3}, "rx level");
        end
        repeat (480) @(posedge clk);
        rdChk(uart_irq_pkg::ADDR_RAW, 32'h00000004, 32'h00000000, "timeout early");
        repeat (40) @(posedge clk);
        rdChk(uart_irq_pkg::ADDR_RAW, 32'h00000004, 32'h00000004, "timeout");
        apb(1'b1, uart_irq_pkg::ADDR_CLEAR, 32'h0000007F);
        n0 = u_node.gotCount;
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < 6; i++) begin
                b0 = 8'($urandom);
                apb(1'b1, uart_irq_pkg::ADDR_DATA, {24'h000000, b0});
            end
            rdChk(uart_irq_pkg::ADDR_RAW, 32'h00000002, 32'h00000000, "tx above level");
            waitRx(n0 + 6 * (r + 1));
            rdChk(uart_irq_pkg::ADDR_RAW, 32'h00000002, 32'h00000002, "tx at level");
            chk({24'h000000, u_node.gotByte}, {24'h000000, b0}, "tx data");
        end
        apb(1'b1, uart_irq_pkg::ADDR_CTRL, 32'h00000006);
        apb(1'b1, uart_irq_pkg::ADDR_CLEAR, 32'h0000007F);
        n0 = u_node.gotCount;
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        apb(1'b1, uart_irq_pkg::ADDR_DATA, {24'h000000, b0});
        rdChk(uart_irq_pkg::ADDR_RAW, 32'h00000002, 32'h00000002, "tx moved");
        apb(1'b1, uart_irq_pkg::ADDR_DATA, {24'h000000, b1});
        rdChk(uart_irq_pkg::ADDR_RAW, 32'h00000002, 32'h00000000, "tx withdrawn");
        waitRx(n0 + 2);
        rdChk(uart_irq_pkg::ADDR_RAW, 32'h00000002, 32'h00000002, "tx moved again");
        chk({24'h000000, u_node.gotByte}, {24'h000000, b1}, "tx data");
        results();
    end
endmodule // uart_interrupt_timing_tb
`default_nettype wire

/* File: dv/uart_irq_core_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_irq_core_checker #(
    parameter int FIFO_DEPTH = 32,
    parameter logic [15:0] BAUD_DIV_RESET = 16'h0035
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rxd,
    input wire logic txd,
    input wire logic irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_PREADY_CAUSE: assert property (pready |-> $past(psel) && $past(penable) && !$past(pready))
        else $error("pready without access");
    AST_ERR_UNMAPPED: assert property (psel && penable && !pready && paddr > 8'h20 |=> pslverr)
        else $error("no error on unmapped address");
    AST_ERR_MAPPED: assert property (psel && penable && !pready && paddr <= 8'h20 && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("error on mapped address");
    AST_ERR_READ_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h00000000)
        else $error("unmapped read data not zero");
    // only a write can drop a pending event; irq trails the event by one cycle
    AST_EVENT_STICKY: assert property (irq && !psel && !$past(psel) |=> irq)
        else $error("irq dropped without a write");
    AST_RESET_IDLE: assert property (disable iff (1'b0) srst |=> txd && !irq && !pready && !pslverr)
        else $error("outputs not idle after reset");
endmodule // uart_irq_core_checker

bind uart_irq_core uart_irq_core_checker #(
    .FIFO_DEPTH(FIFO_DEPTH),
    .BAUD_DIV_RESET(BAUD_DIV_RESET)
) u_checker (
    .clk(clk),
    .srst(srst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rxd(rxd),
    .txd(txd),
    .irq(irq)
);
`default_nettype wire

/* File: dv/uart_remote_node.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_remote_node #(
    parameter int BIT_CLKS = 16
) (
    input wire logic clk,
    input wire logic txd,
    output logic rxd
);
    logic [7:0] gotByte = 8'h00;
    int gotCount = 0;

    // line rests high between frames, as a pulled-up idle line does
    initial rxd = 1'b1;

    task automatic sendChar(input logic [7:0] d, input logic usePar, input logic par, input logic stopLvl);
        logic [10:0] bits;
        bits = {stopLvl, par, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            if (i != 9 || usePar) begin
                rxd <= bits[i];
                repeat (BIT_CLKS) @(posedge clk);
            end
        end
        rxd <= 1'b1;
        @(posedge clk);
    endtask

    // mid-bit sampling, lsb first; stop level is not judged here
    initial forever begin
        @(negedge txd);
        repeat (BIT_CLKS / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clk);
            gotByte[i] = txd;
        end
        repeat (BIT_CLKS) @(posedge clk);
        gotCount++;
    end
endmodule // uart_remote_node
`default_nettype wire

/* File: src/uart_irq_core.sv */
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module uart_irq_core #(
    parameter int FIFO_DEPTH = 32,
    parameter logic [15:0] BAUD_DIV_RESET = 16'h0035
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd,
    output logic txd,
    output logic irq
);
    localparam int PW = $clog2(FIFO_DEPTH);
    localparam int CW = PW + 1;

    if (FIFO_DEPTH < 8 || (1 << PW) != FIFO_DEPTH) begin : g_bad_depth
        $error("FIFO_DEPTH must be a power of two of at least 8");
    end

    // threshold level in characters for a select code
    function automatic logic [CW-1:0] level(input logic [2:0] sel);
        logic [CW-1:0] e;
        e = CW'(FIFO_DEPTH / 8);
        case (sel)
            uart_irq_pkg::SEL_EIGHTH: level = e;
            uart_irq_pkg::SEL_QUARTER: level = CW'(e * 2);
            uart_irq_pkg::SEL_HALF: level = CW'(e * 4);
            uart_irq_pkg::SEL_THREEQ: level = CW'(e * 6);
            default: level = CW'(e * 7);
        endcase
    endfunction

    logic [uart_irq_pkg::CTRL_W-1:0] ctrl_ff;
    logic [15:0] baudDiv_ff;
    logic [5:0] levelSel_ff;
    uart_irq_pkg::irqEvents_t raw_ff, mask_ff, nxt_raw;
    logic [15:0] divCnt_ff;
    logic sixteenXBaudTick_ff;

    // apb slave: one wait state, answer on the second access cycle
    logic access, wrAccess, rdAccess, known;
    // writes and the receive pop commit on the first access edge, pready follows it
    assign access = psel && penable && !pready;
    assign wrAccess = access && pwrite;
    assign rdAccess = access && !pwrite;
    always_comb begin
        known = 1'b1;
        if (paddr == uart_irq_pkg::ADDR_DATA) known = 1'b1;
        else if (paddr == uart_irq_pkg::ADDR_FLAG) known = 1'b1;
        else if (paddr == uart_irq_pkg::ADDR_CTRL) known = 1'b1;
        else if (paddr == uart_irq_pkg::ADDR_BAUD) known = 1'b1;
        else if (paddr == uart_irq_pkg::ADDR_LEVEL) known = 1'b1;
        else if (paddr == uart_irq_pkg::ADDR_RAW) known = 1'b1;
        else if (paddr == uart_irq_pkg::ADDR_MASK) known = 1'b1;
        else if (paddr == uart_irq_pkg::ADDR_MASKED) known = 1'b1;
        else if (paddr == uart_irq_pkg::ADDR_CLEAR) known = 1'b1;
        else known = 1'b0;
    end

    logic fifoOn;
    assign fifoOn = ctrl_ff[uart_irq_pkg::CTRL_FIFO_EN];
    logic [CW-1:0] capacity;
    assign capacity = fifoOn ? CW'(FIFO_DEPTH) : CW'(1);

    // fifos: depth one acts as the single holding buffer when fifos are off
    logic [7:0] txMem [FIFO_DEPTH];
    logic [7:0] rxMem [FIFO_DEPTH];
    logic [7:0] rxShift_ff;
    logic [PW-1:0] txWr_ff, txRd_ff, rxWr_ff, rxRd_ff;
    logic [CW-1:0] txCount_ff, rxCount_ff;
    logic txPush, txPop, rxPush, rxPop;
    logic dataWrite;
    assign dataWrite = wrAccess && paddr == uart_irq_pkg::ADDR_DATA;
    // a write into a full transmit fifo is dropped with no error response
    assign txPush = dataWrite && txCount_ff < capacity;
    assign rxPop = rdAccess && paddr == uart_irq_pkg::ADDR_DATA && rxCount_ff != '0;

    always_ff @(posedge clk) begin
        if (txPush) txMem[txWr_ff] <= pwdata[7:0];
        if (rxPush) rxMem[rxWr_ff] <= rxShift_ff;
    end

    always_ff @(posedge clk) begin
        if (srst || (wrAccess && paddr == uart_irq_pkg::ADDR_CTRL)) begin
            // changing the mode flushes both fifos
            txWr_ff <= '0;
            txRd_ff <= '0;
            txCount_ff <= '0;
            rxWr_ff <= '0;
            rxRd_ff <= '0;
            rxCount_ff <= '0;
        end else begin
            if (txPush) txWr_ff <= txWr_ff + 1'b1;
            if (txPop) txRd_ff <= txRd_ff + 1'b1;
            txCount_ff <= txCount_ff + CW'(txPush) - CW'(txPop);
            if (rxPush) rxWr_ff <= rxWr_ff + 1'b1;
            if (rxPop) rxRd_ff <= rxRd_ff + 1'b1;
            rxCount_ff <= rxCount_ff + CW'(rxPush) - CW'(rxPop);
        end
    end

    // sixteen-times-baud enable pulse
    always_ff @(posedge clk) begin
        if (srst || divCnt_ff >= baudDiv_ff) begin
            divCnt_ff <= '0;
            sixteenXBaudTick_ff <= !srst;
        end else begin
            divCnt_ff <= divCnt_ff + 1'b1;
            sixteenXBaudTick_ff <= 1'b0;
        end
    end

    // transmitter
    uart_irq_pkg::txState_t txState_ff;
    logic [7:0] txShift_ff;
    logic [3:0] txTick_ff;
    logic [2:0] txBit_ff;
    logic txLoad, txStopStart, txBitEnd;
    // the holding buffer empties on the edge the shifter loads
    assign txLoad = txState_ff == uart_irq_pkg::TX_IDLE && txCount_ff != '0
        && ctrl_ff[uart_irq_pkg::CTRL_TX_EN];
    assign txPop = txLoad;
    assign txBitEnd = sixteenXBaudTick_ff && txTick_ff == uart_irq_pkg::OVERSAMPLE_LAST;
    assign txStopStart = txBitEnd && ((txState_ff == uart_irq_pkg::TX_DATA
        && txBit_ff == uart_irq_pkg::DATA_LAST && !ctrl_ff[uart_irq_pkg::CTRL_PAR_EN])
        || txState_ff == uart_irq_pkg::TX_PARITY);

    always_ff @(posedge clk) begin
        if (srst) begin
            txState_ff <= uart_irq_pkg::TX_IDLE;
            txShift_ff <= '0;
            txTick_ff <= '0;
            txBit_ff <= '0;
            txd <= 1'b1;
        end else begin
            if (sixteenXBaudTick_ff) txTick_ff <= txTick_ff + 1'b1;
            case (txState_ff)
                uart_irq_pkg::TX_IDLE: begin
                    txd <= 1'b1;
                    txTick_ff <= '0;
                    if (txLoad) begin
                        txShift_ff <= txMem[txRd_ff];
                        txState_ff <= uart_irq_pkg::TX_START;
                        txd <= 1'b0;
                    end
                end
                uart_irq_pkg::TX_START: begin
                    if (txBitEnd) begin
                        txState_ff <= uart_irq_pkg::TX_DATA;
                        txBit_ff <= '0;
                        txd <= txShift_ff[0];
                    end
                end
                uart_irq_pkg::TX_DATA: begin
                    if (txStopStart) begin
                        txState_ff <= uart_irq_pkg::TX_STOP;
                        txd <= 1'b1;
                    end else if (txBitEnd && txBit_ff == uart_irq_pkg::DATA_LAST) begin
                        txState_ff <= uart_irq_pkg::TX_PARITY;
                        txd <= ^txShift_ff ^ ctrl_ff[uart_irq_pkg::CTRL_PAR_ODD];
                    end else if (txBitEnd) begin
                        txBit_ff <= txBit_ff + 1'b1;
                        txd <= txShift_ff[txBit_ff + 3'h1];
                    end
                end
                uart_irq_pkg::TX_PARITY: begin
                    if (txStopStart) begin
                        txState_ff <= uart_irq_pkg::TX_STOP;
                        txd <= 1'b1;
                    end
                end
                default: begin
                    if (txBitEnd) txState_ff <= uart_irq_pkg::TX_IDLE;
                end
            endcase
        end
    end

    // receiver, sampling mid-bit on the sixteen-times tick
    uart_irq_pkg::rxState_t rxState_ff;
    logic [3:0] rxTick_ff;
    logic [2:0] rxBit_ff;
    logic rxSample, stopSampled, parityBad, rxFull;
    assign rxSample = sixteenXBaudTick_ff && rxTick_ff == uart_irq_pkg::OVERSAMPLE_LAST;
    assign stopSampled = rxState_ff == uart_irq_pkg::RX_STOP && rxSample;
    assign parityBad = rxState_ff == uart_irq_pkg::RX_PARITY && rxSample
        && (rxd != (^rxShift_ff ^ ctrl_ff[uart_irq_pkg::CTRL_PAR_ODD]));
    // a full receive fifo loses the incoming character; the overrun event reports it
    assign rxFull = rxCount_ff >= capacity;
    assign rxPush = stopSampled && !rxFull;

    always_ff @(posedge clk) begin
        if (srst) begin
            rxState_ff <= uart_irq_pkg::RX_IDLE;
            rxShift_ff <= '0;
            rxTick_ff <= '0;
            rxBit_ff <= '0;
        end else if (sixteenXBaudTick_ff) begin
            rxTick_ff <= rxTick_ff + 1'b1;
            case (rxState_ff)
                uart_irq_pkg::RX_IDLE: begin
                    rxTick_ff <= '0;
                    if (!rxd && ctrl_ff[uart_irq_pkg::CTRL_RX_EN]) rxState_ff <= uart_irq_pkg::RX_START;
                end
                uart_irq_pkg::RX_START: begin
                    // re-centre on the middle of the start bit; a glitch returns to idle
                    if (rxTick_ff == uart_irq_pkg::OVERSAMPLE_MID) begin
                        rxTick_ff <= '0;
                        rxBit_ff <= '0;
                        rxState_ff <= rxd ? uart_irq_pkg::RX_IDLE : uart_irq_pkg::RX_DATA;
                    end
                end
                uart_irq_pkg::RX_DATA: begin
                    if (rxSample) begin
                        rxShift_ff <= {rxd, rxShift_ff[7:1]};
                        rxBit_ff <= rxBit_ff + 1'b1;
                        if (rxBit_ff == uart_irq_pkg::DATA_LAST) begin
                            rxState_ff <= ctrl_ff[uart_irq_pkg::CTRL_PAR_EN] ? uart_irq_pkg::RX_PARITY
                                : uart_irq_pkg::RX_STOP;
                        end
                    end
                end
                uart_irq_pkg::RX_PARITY: begin
                    if (rxSample) rxState_ff <= uart_irq_pkg::RX_STOP;
                end
                default: begin
                    if (rxSample) rxState_ff <= uart_irq_pkg::RX_IDLE;
                end
            endcase
        end
    end

    // receive timeout: counts ticks while data waits and the line and fifo stay quiet
    logic [8:0] idleTicks_ff;
    logic timeoutHit;
    assign timeoutHit = sixteenXBaudTick_ff && idleTicks_ff == 9'(uart_irq_pkg::TIMEOUT_TICKS - 1);
    always_ff @(posedge clk) begin
        if (srst || rxCount_ff == '0 || rxPop || rxPush || rxState_ff != uart_irq_pkg::RX_IDLE) begin
            idleTicks_ff <= '0;
        // parking at the limit keeps one idle spell from raising the event twice
        end else if (sixteenXBaudTick_ff && idleTicks_ff != 9'(uart_irq_pkg::TIMEOUT_TICKS)) begin
            idleTicks_ff <= idleTicks_ff + 1'b1;
        end
    end

    // event status: a set in the same cycle as a clear wins
    uart_irq_pkg::irqEvents_t setEv, clrEv;
    logic [CW-1:0] txLevel, rxLevel;
    assign txLevel = level(levelSel_ff[uart_irq_pkg::TX_SEL_LSB +: uart_irq_pkg::SEL_W]);
    assign rxLevel = level(levelSel_ff[uart_irq_pkg::RX_SEL_LSB +: uart_irq_pkg::SEL_W]);
    always_comb begin
        setEv = '0;
        clrEv = '0;
        setEv.overrun = stopSampled && rxFull;
        // a break also reads low at the stop position, so framing rises with it
        setEv.brk = stopSampled && !rxd && rxShift_ff == '0;
        setEv.parity = parityBad;
        setEv.framing = stopSampled && !rxd;
        setEv.timeout = timeoutHit;
        if (fifoOn) begin
            setEv.rx = rxPush && (rxCount_ff + CW'(1)) == rxLevel;
            setEv.tx = txStopStart && txCount_ff == txLevel;
            // refilling above the threshold withdraws the event with no software clear
            clrEv.tx = txCount_ff > txLevel;
        end else begin
            setEv.rx = stopSampled;
            setEv.tx = txLoad;
            clrEv.tx = dataWrite;
        end
        if (wrAccess && paddr == uart_irq_pkg::ADDR_CLEAR) begin
            clrEv = clrEv | uart_irq_pkg::irqEvents_t'(pwdata[uart_irq_pkg::EVT_W-1:0]);
        end
        nxt_raw = (raw_ff & ~clrEv) | setEv;
    end

    always_ff @(posedge clk) begin
        if (srst) raw_ff <= '0;
        else raw_ff <= nxt_raw;
    end

    always_ff @(posedge clk) begin
        // irq trails the status by one cycle, the price of a registered output
        if (srst) irq <= 1'b0;
        else irq <= |(raw_ff & mask_ff);
    end

    // configuration registers
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_ff <= uart_irq_pkg::CTRL_RESET;
            baudDiv_ff <= BAUD_DIV_RESET;
            levelSel_ff <= uart_irq_pkg::LEVEL_RESET;
            mask_ff <= '0;
        end else if (wrAccess) begin
            if (paddr == uart_irq_pkg::ADDR_CTRL) ctrl_ff <= pwdata[uart_irq_pkg::CTRL_W-1:0];
            else if (paddr == uart_irq_pkg::ADDR_BAUD) baudDiv_ff <= pwdata[15:0];
            else if (paddr == uart_irq_pkg::ADDR_LEVEL) levelSel_ff <= pwdata[5:0];
            else if (paddr == uart_irq_pkg::ADDR_MASK) mask_ff <= pwdata[uart_irq_pkg::EVT_W-1:0];
        end
    end

    // read mux and handshake
    logic [31:0] rdValue;
    logic txBusy;
    assign txBusy = txState_ff != uart_irq_pkg::TX_IDLE || txCount_ff != '0;
    always_comb begin
        rdValue = '0;
        if (paddr == uart_irq_pkg::ADDR_DATA) rdValue = {24'h000000, rxCount_ff != '0 ? rxMem[rxRd_ff] : 8'h00};
        else if (paddr == uart_irq_pkg::ADDR_FLAG) begin
            rdValue = {8'h00, 8'(rxCount_ff), 8'(txCount_ff), 3'h0, txBusy, rxFull,
                txCount_ff >= capacity, rxCount_ff == '0, txCount_ff == '0};
        end
        else if (paddr == uart_irq_pkg::ADDR_CTRL) rdValue = 32'(ctrl_ff);
        else if (paddr == uart_irq_pkg::ADDR_BAUD) rdValue = 32'(baudDiv_ff);
        else if (paddr == uart_irq_pkg::ADDR_LEVEL) rdValue = 32'(levelSel_ff);
        else if (paddr == uart_irq_pkg::ADDR_RAW) rdValue = 32'(raw_ff);
        else if (paddr == uart_irq_pkg::ADDR_MASK) rdValue = 32'(mask_ff);
        else if (paddr == uart_irq_pkg::ADDR_MASKED) rdValue = 32'(raw_ff & mask_ff);
        else rdValue = '0;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= access;
            pslverr <= access && !known;
            if (rdAccess) prdata <= rdValue;
        end
    end

endmodule // uart_irq_core
`default_nettype wire

/* File: src/uart_irq_pkg.sv */
package uart_irq_pkg;

    localparam logic [7:0] ADDR_DATA = 8'h00;
    localparam logic [7:0] ADDR_FLAG = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_BAUD = 8'h0C;
    localparam logic [7:0] ADDR_LEVEL = 8'h10;
    localparam logic [7:0] ADDR_RAW = 8'h14;
    localparam logic [7:0] ADDR_MASK = 8'h18;
    localparam logic [7:0] ADDR_MASKED = 8'h1C;
    localparam logic [7:0] ADDR_CLEAR = 8'h20;

    // control register fields
    localparam int CTRL_FIFO_EN = 0;
    localparam int CTRL_TX_EN = 1;
    localparam int CTRL_RX_EN = 2;
    localparam int CTRL_PAR_EN = 3;
    localparam int CTRL_PAR_ODD = 4;
    localparam int CTRL_W = 5;
    localparam logic [4:0] CTRL_RESET = 5'h06;

    // level register: tx_threshold_select low, receive select above it
    localparam int TX_SEL_LSB = 0;
    localparam int RX_SEL_LSB = 3;
    localparam int SEL_W = 3;
    localparam logic [5:0] LEVEL_RESET = 6'h12;

    // threshold encodings in eighths of the fifo depth
    localparam logic [2:0] SEL_EIGHTH = 3'h0;
    localparam logic [2:0] SEL_QUARTER = 3'h1;
    localparam logic [2:0] SEL_HALF = 3'h2;
    localparam logic [2:0] SEL_THREEQ = 3'h3;
    localparam logic [2:0] SEL_SEVENE = 3'h4;

    localparam int TIMEOUT_TICKS = 511;
    localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
    localparam logic [3:0] OVERSAMPLE_MID = 4'h7;
    localparam logic [2:0] DATA_LAST = 3'h7;

    typedef struct packed {
        logic overrun;
        logic brk;
        logic parity;
        logic framing;
        logic timeout;
        logic tx;
        logic rx;
    } irqEvents_t;

    localparam int EVT_W = 7;

    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} txState_t;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rxState_t;

endpackage
